// ---- rtl/lpm_pkg.sv ----
// Shared constants for the low-power mode entry and exit pair
package lpm_pkg;
	// ***************************************************************
	// Device-side register select codes and fields
	// ***************************************************************
	localparam logic [1:0] LPM_SEL_PROTECT  = 2'h0; // Write-protect register
	localparam logic [1:0] LPM_SEL_CM1      = 2'h1; // Clock mode register one
	localparam logic [1:0] LPM_SEL_WAKE_LVL = 2'h2; // Wake level register
	localparam int         LPM_UNLOCK_POS   = 0;    // Clock write-unlock bit
	localparam int         LPM_STOP_POS     = 0;    // All-clock-stop bit
	localparam int         LPM_LVL_W        = 3;    // Threshold and priority width
	localparam logic [2:0] LPM_THR_MAX      = 3'h7; // Threshold that blocks all maskable wakes
	localparam logic [2:0] LPM_THR_RST      = 3'h0; // Threshold after reset
	// ***************************************************************
	// Controller APB register map
	// ***************************************************************
	localparam logic [11:0] LPM_OFF_CTRL   = 12'h000; // Command register
	localparam logic [11:0] LPM_OFF_CFG    = 12'h004; // Priority setup register
	localparam logic [11:0] LPM_OFF_STATUS = 12'h008; // Status register
	localparam int CTRL_STOP_POS  = 0; // Enter stop mode
	localparam int CTRL_WAIT_POS  = 1; // Enter wait mode
	localparam int CTRL_RESET_POS = 2; // Hardware reset of the device
	localparam int CTRL_NMI_POS   = 3; // Raise the non-maskable interrupt
	localparam int CFG_PRIO_POS   = 0; // Wake source priority, 3 bits
	localparam int CFG_IPL_POS    = 4; // Processor priority level, 3 bits
	localparam int ST_BUSY_POS    = 0; // Sequence in progress
	localparam int ST_STOP_POS    = 1; // Device in stop mode
	localparam int ST_WAIT_POS    = 2; // Device in wait mode
	localparam int ST_DUMMY_POS   = 3; // Dummy interrupt owed
	localparam int ST_WOKE_POS    = 4; // Sticky: a wake was serviced
	localparam int ST_THR_POS     = 8; // Threshold readback, 3 bits
	localparam logic [7:0] LPM_CFG_RST = 8'h00; // Priority setup reset value
	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_PERIOD_NS  = 20;    // pclk period
	localparam int OSC_STABLE_NS  = 10000; // Oscillator settle time
	localparam int OSC_STABLE_CYC = (OSC_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_NOP_SLOTS = 4;     // Slots after the wait instruction
	localparam int STOP_SLOTS     = 5;     // Short jump plus four slots
endpackage : lpm_pkg

// ---- rtl/lpm_if.sv ----
// Link between the CPU-side controller and the low-power device logic
`timescale 1ns/1ps
interface lpm_if;
	logic       wr_valid;   // Register write strobe
	logic [1:0] wr_addr;    // Register select
	logic [7:0] wr_data;    // Register write data
	logic       wait_exec;  // Wait instruction executed
	logic       int_enable; // Interrupt enable flag
	logic [2:0] processor_priority_level;        // Processor priority level
	logic       irq_req;    // Maskable interrupt request
	logic [2:0] irq_level;  // Its priority level
	logic       nmi_req;    // Non-maskable interrupt request
	logic       dummy_int;  // Dummy software interrupt
	logic       dev_rst_n;  // Hardware reset, active low
	logic       clk_run;    // Clocks running
	logic       in_stop;    // Stop mode
	logic       in_wait;    // Wait mode
	logic       queue_exec; // Queued instruction executed
	logic       irq_taken;  // Interrupt service started
	logic       wake_nmi;   // Last service was the NMI
	logic [2:0] thr_rd;     // Threshold readback
	modport cpu (output wr_valid, wr_addr, wr_data, wait_exec, int_enable, processor_priority_level,
		irq_req, irq_level, nmi_req, dummy_int, dev_rst_n,
		input clk_run, in_stop, in_wait, queue_exec, irq_taken, wake_nmi, thr_rd);
	modport dev (input wr_valid, wr_addr, wr_data, wait_exec, int_enable, processor_priority_level,
		irq_req, irq_level, nmi_req, dummy_int, dev_rst_n,
		output clk_run, in_stop, in_wait, queue_exec, irq_taken, wake_nmi, thr_rd);
endinterface : lpm_if

// ---- rtl/lpm_delay.sv ----
// Down counter that times reset hold and instruction slots
`timescale 1ns/1ps
module lpm_delay #(
	parameter int W = 10 // Counter width
) (
	input  wire logic         pclk,    // System clock
	input  wire logic         presetn, // Async reset, active low
	input  wire logic         load,    // Start a new count
	input  wire logic [W-1:0] count,   // Cycles to run
	output logic              busy     // High while counting
);
	logic [W-1:0] left;

	// Count down to zero; a load restarts at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= '0;
		end else if (load) begin
			left <= count;
		end else if (left != '0) begin
			left <= left - 1'b1;
		end
	end

	assign busy = (left != '0);
endmodule : lpm_delay

// ---- rtl/lpm_cpu.sv ----
// CPU-side controller: APB registers and entry, exit and reset sequences
// Operation
// [RULE1] Reset held low until oscillator settles
// [RULE2] Four no-op slots after wait instruction
// [RULE3] Queued instruction runs before wake interrupt
// [RULE4] Short jump then four no-ops after stop
// [RULE5] Stop bit writable only while unlocked
// [RULE6] Threshold is three bits, set to seven
// [RULE7] Wake only when level exceeds threshold
// [RULE8] Other interrupt priorities set to zero
// [RULE9] Threshold equals processor level, then enable
// [RULE10] Threshold back to seven after exit
// [RULE11] Dummy interrupt after NMI exit before stop
// [RULE12] Wait instruction enters wait after preparation
// [RULE13] Accepted wake restarts clocks and CPU
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module lpm_cpu
	import lpm_pkg::*;
#(
	parameter int OSC_CYC = lpm_pkg::OSC_STABLE_CYC // Reset hold in cycles
) (
	input  wire logic        pclk,    // System clock
	input  wire logic        presetn, // Async reset, active low
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB direction
	input  wire logic [11:0] paddr,   // APB address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic [31:0]      prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr, // APB error
	input  wire logic        irq_in,  // Wake source request level
	lpm_if.cpu               lnk      // Link to the device
);
	typedef enum logic [3:0] {
		LPC_INIT, LPC_IDLE, LPC_DUMMY, LPC_THR, LPC_IE, LPC_UNLOCK, LPC_STOPW,
		LPC_WAITI, LPC_SLOTS, LPC_SLEEP, LPC_RESTORE, LPC_RELOCK, LPC_RST, LPC_RSTH
	} lpm_cst_e;

	typedef struct packed {
		lpm_cst_e   st;      // Sequencer state
		logic       is_stop; // Current entry is stop mode
		logic [7:0] cfg;     // Priority setup
		logic       owe_dmy; // Dummy interrupt owed
		logic       woke;    // Sticky wake seen
		logic       ie;      // Interrupt enable flag
		logic       nmi;     // NMI raised
		logic       wv;      // Write strobe
		logic [1:0] wa;      // Write select
		logic [7:0] wd;      // Write data
		logic       wexec;   // Wait instruction pulse
		logic       dmy;     // Dummy interrupt pulse
		logic       rst_n;   // Device reset
		logic [2:0] thr;     // Last threshold written
		logic       ld;      // Delay load
		logic [9:0] ldv;     // Delay count
		logic       seq_wk;  // Wake seen in this sequence
	} lpm_cpu_s;

	lpm_cpu_s r, next_r;
	logic     dly_busy;
	logic     wr_acc;

	lpm_delay #(.W(10)) u_dly (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (r.ld),
		.count   (r.ldv),
		.busy    (dly_busy)
	);

	// ***************************************************************
	// APB slave, zero wait states
	// ***************************************************************
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_acc  = psel && penable && pwrite;

	// Read mux; unmapped offsets read zero
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			LPM_OFF_CFG: prdata[7:0] = r.cfg;
			LPM_OFF_STATUS: begin
				prdata[ST_BUSY_POS]  = (r.st != LPC_IDLE);
				prdata[ST_STOP_POS]  = lnk.in_stop;
				prdata[ST_WAIT_POS]  = lnk.in_wait;
				prdata[ST_DUMMY_POS] = r.owe_dmy;
				prdata[ST_WOKE_POS]  = r.woke;
				prdata[ST_THR_POS +: 3] = r.thr;
			end
			default: prdata = 32'h0000_0000;
		endcase
	end

	// ***************************************************************
	// Sequencer
	// ***************************************************************
	always_comb begin
		next_r       = r;
		next_r.wv    = 1'b0;
		next_r.wexec = 1'b0;
		next_r.dmy   = 1'b0;
		next_r.ld    = 1'b0;
		// Only the chosen source carries a level, all others sit at zero
		if (wr_acc && paddr == LPM_OFF_CFG) next_r.cfg = pwdata[7:0]; // [RULE8]
		if (wr_acc && paddr == LPM_OFF_STATUS && pwdata[ST_WOKE_POS]) next_r.woke = 1'b0;
		if (lnk.irq_taken) begin
			next_r.nmi = 1'b0;
			if (lnk.wake_nmi && r.st != LPC_IDLE) next_r.owe_dmy = 1'b1; // [RULE11]
		end
		if (lnk.irq_taken && (r.st == LPC_SLOTS || r.st == LPC_SLEEP)) begin
			next_r.woke   = 1'b1;
			next_r.seq_wk = 1'b1;
		end
		// NMI may be raised at any time
		if (wr_acc && paddr == LPM_OFF_CTRL && pwdata[CTRL_NMI_POS]) next_r.nmi = 1'b1;
		unique case (r.st)
			LPC_INIT: begin
				// Block every maskable wake before any priority is handed out
				next_r.wv = 1'b1; // [RULE6]
				next_r.wa = LPM_SEL_WAKE_LVL;
				next_r.wd = {5'h00, LPM_THR_MAX};
				next_r.thr = LPM_THR_MAX;
				next_r.st = LPC_IDLE;
			end
			LPC_IDLE: begin
				if (wr_acc && paddr == LPM_OFF_CTRL) begin
					if (pwdata[CTRL_RESET_POS]) begin
						next_r.st = LPC_RST;
					end else if (pwdata[CTRL_STOP_POS]) begin
						next_r.is_stop = 1'b1;
						next_r.st = r.owe_dmy ? LPC_DUMMY : LPC_THR; // [RULE11]
					end else if (pwdata[CTRL_WAIT_POS]) begin
						next_r.is_stop = 1'b0;
						next_r.st = LPC_THR; // [RULE12]
					end
				end
			end
			LPC_DUMMY: begin
				next_r.dmy = 1'b1; // [RULE11]
				// An NMI service in this very cycle still leaves a debt
				next_r.owe_dmy = lnk.irq_taken && lnk.wake_nmi;
				next_r.st = LPC_THR;
			end
			LPC_THR: begin
				// Threshold follows the processor level already set
				next_r.wv = 1'b1; // [RULE9]
				next_r.wa = LPM_SEL_WAKE_LVL;
				next_r.wd = {5'h00, r.cfg[CFG_IPL_POS +: 3]};
				next_r.thr = r.cfg[CFG_IPL_POS +: 3];
				next_r.st = LPC_IE;
			end
			LPC_IE: begin
				next_r.ie = 1'b1; // [RULE9]
				next_r.st = r.is_stop ? LPC_UNLOCK : LPC_WAITI;
			end
			LPC_UNLOCK: begin
				next_r.wv = 1'b1; // [RULE5]
				next_r.wa = LPM_SEL_PROTECT;
				next_r.wd = 8'h01;
				next_r.st = LPC_STOPW;
			end
			LPC_STOPW: begin
				next_r.wv = 1'b1; // [RULE5]
				next_r.wa = LPM_SEL_CM1;
				next_r.wd = 8'h01;
				next_r.ld = 1'b1; // [RULE4]
				next_r.ldv = 10'(STOP_SLOTS);
				next_r.st = LPC_SLOTS;
			end
			LPC_WAITI: begin
				next_r.wexec = 1'b1; // [RULE12]
				next_r.ld = 1'b1; // [RULE2]
				next_r.ldv = 10'(WAIT_NOP_SLOTS);
				next_r.st = LPC_SLOTS;
			end
			LPC_SLOTS: begin
				// Filler slots so the prefetched queue holds only no-ops
				if (!dly_busy && !r.ld) next_r.st = LPC_SLEEP; // [RULE2] [RULE4]
			end
			LPC_SLEEP: begin
				// The sticky status bit is software's; a stale one must not end a sleep
				if (lnk.irq_taken || r.seq_wk) next_r.st = LPC_RESTORE;
			end
			LPC_RESTORE: begin
				next_r.wv = 1'b1; // [RULE10]
				next_r.seq_wk = 1'b0;
				next_r.wa = LPM_SEL_WAKE_LVL;
				next_r.wd = {5'h00, LPM_THR_MAX};
				next_r.thr = LPM_THR_MAX;
				next_r.st = r.is_stop ? LPC_RELOCK : LPC_IDLE;
			end
			LPC_RELOCK: begin
				next_r.wv = 1'b1;
				next_r.wa = LPM_SEL_PROTECT;
				next_r.wd = 8'h00;
				next_r.st = LPC_IDLE;
			end
			LPC_RST: begin
				// Hold reset low until the oscillator has settled
				next_r.rst_n = 1'b0; // [RULE1]
				next_r.ld = 1'b1;
				next_r.ldv = 10'(OSC_CYC);
				next_r.st = LPC_RSTH;
			end
			LPC_RSTH: begin
				if (!dly_busy && !r.ld) begin
					next_r.rst_n = 1'b1; // [RULE1]
					next_r.ie = 1'b0;
					next_r.owe_dmy = 1'b0;
					next_r.nmi = 1'b0;
					next_r.st = LPC_INIT;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{st: LPC_INIT, is_stop: 1'b0, cfg: LPM_CFG_RST, owe_dmy: 1'b0,
				woke: 1'b0, ie: 1'b0, nmi: 1'b0, wv: 1'b0, wa: 2'h0, wd: 8'h00,
				wexec: 1'b0, dmy: 1'b0, rst_n: 1'b1, thr: LPM_THR_RST,
				ld: 1'b0, ldv: 10'h000, seq_wk: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// ***************************************************************
	// Link drive
	// ***************************************************************
	assign lnk.wr_valid   = r.wv;
	assign lnk.wr_addr    = r.wa;
	assign lnk.wr_data    = r.wd;
	assign lnk.wait_exec  = r.wexec;
	assign lnk.int_enable = r.ie;
	assign lnk.processor_priority_level        = r.cfg[CFG_IPL_POS +: 3];
	assign lnk.irq_req    = irq_in;
	assign lnk.irq_level  = r.cfg[CFG_PRIO_POS +: 3]; // [RULE8]
	assign lnk.nmi_req    = r.nmi;
	assign lnk.dummy_int  = r.dmy;
	assign lnk.dev_rst_n  = r.rst_n;
endmodule : lpm_cpu

// ---- rtl/lpm_dev.sv ----
// Device end: stop and wait entry, threshold-qualified wake, exit ordering
`timescale 1ns/1ps
module lpm_dev
	import lpm_pkg::*;
(
	input  wire logic pclk,     // System clock
	input  wire logic presetn,  // Async reset, active low
	lpm_if.dev        lnk,      // Link to the CPU side
	output logic      cpu_run,  // CPU clock enable
	output logic      stop_bit  // All-clock-stop bit state
);
	typedef enum logic [2:0] {LPD_RUN, LPD_STOP, LPD_WAIT, LPD_QEXEC, LPD_SVC} lpm_dst_e;

	typedef struct packed {
		lpm_dst_e   st;      // Mode state
		logic       unlock;  // Clock write-unlock bit
		logic       stopb;   // All-clock-stop bit
		logic [2:0] thr;     // Exit priority threshold
		logic       qexec;   // Queue execute pulse
		logic       taken;   // Service pulse
		logic       by_nmi;  // Wake cause was the NMI
		logic       held;    // Request already serviced
	} lpm_dev_s;

	lpm_dev_s r, next_r;
	logic     wake_ok;
	logic     run_ok;

	// ***************************************************************
	// Wake and service qualification
	// ***************************************************************
	// NMI cannot be masked; others must beat the threshold strictly
	assign wake_ok = lnk.nmi_req ||
		(lnk.irq_req && lnk.int_enable && (lnk.irq_level > r.thr)); // [RULE7]
	// Normal acceptance while running uses the processor level
	assign run_ok  = !r.held && (lnk.nmi_req || lnk.dummy_int ||
		(lnk.irq_req && lnk.int_enable && (lnk.irq_level > lnk.processor_priority_level)));

	always_comb begin
		next_r       = r;
		next_r.qexec = 1'b0;
		next_r.taken = 1'b0;
		if (!lnk.irq_req && !lnk.nmi_req) next_r.held = 1'b0;
		// Register writes from the CPU
		if (lnk.wr_valid) begin
			unique case (lnk.wr_addr)
				LPM_SEL_PROTECT: next_r.unlock = lnk.wr_data[LPM_UNLOCK_POS];
				LPM_SEL_CM1: begin
					if (r.unlock) next_r.stopb = lnk.wr_data[LPM_STOP_POS]; // [RULE5]
				end
				LPM_SEL_WAKE_LVL: next_r.thr = lnk.wr_data[2:0]; // [RULE6]
				default: next_r = next_r;
			endcase
		end
		unique case (r.st)
			LPD_RUN: begin
				if (lnk.wr_valid && lnk.wr_addr == LPM_SEL_CM1 && r.unlock &&
					lnk.wr_data[LPM_STOP_POS]) begin
					next_r.st = LPD_STOP; // [RULE5]
				end else if (lnk.wait_exec) begin
					next_r.st = LPD_WAIT; // [RULE12]
				end else if (run_ok) begin
					next_r.taken  = 1'b1;
					next_r.by_nmi = lnk.nmi_req;
					next_r.held   = !lnk.dummy_int;
				end
			end
			LPD_STOP, LPD_WAIT: begin
				if (wake_ok) begin // [RULE7]
					next_r.st     = LPD_QEXEC; // [RULE13]
					next_r.stopb  = 1'b0;
					next_r.by_nmi = lnk.nmi_req;
					next_r.qexec  = 1'b1;
				end
			end
			LPD_QEXEC: begin
				// The prefetched instruction retires before the vector
				next_r.st = LPD_SVC; // [RULE3]
			end
			LPD_SVC: begin
				next_r.taken = 1'b1; // [RULE13]
				next_r.held  = 1'b1;
				next_r.st    = LPD_RUN;
			end
		endcase
		// Hardware reset ends any mode at once
		if (!lnk.dev_rst_n) begin
			next_r = '{st: LPD_RUN, unlock: 1'b0, stopb: 1'b0, thr: LPM_THR_RST,
				qexec: 1'b0, taken: 1'b0, by_nmi: 1'b0, held: 1'b0};
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{st: LPD_RUN, unlock: 1'b0, stopb: 1'b0, thr: LPM_THR_RST,
				qexec: 1'b0, taken: 1'b0, by_nmi: 1'b0, held: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	// Wait mode keeps peripheral clocks; stop halts all of them
	assign lnk.clk_run    = (r.st != LPD_STOP); // [RULE5]
	assign lnk.in_stop    = (r.st == LPD_STOP);
	assign lnk.in_wait    = (r.st == LPD_WAIT);
	assign lnk.queue_exec = r.qexec;
	assign lnk.irq_taken  = r.taken;
	assign lnk.wake_nmi   = r.by_nmi;
	assign lnk.thr_rd     = r.thr;
	assign cpu_run        = (r.st == LPD_RUN) || (r.st == LPD_QEXEC) || (r.st == LPD_SVC);
	assign stop_bit       = r.stopb;
endmodule : lpm_dev

// ---- verif/lpm_properties.sv ----
// Link assertions for the low-power controller and device pair
`timescale 1ns/1ps
module lpm_properties
	import lpm_pkg::*;
#(
	parameter int OSC_CYC = 8 // Reset hold in cycles
) (
	input wire logic       pclk,       // System clock
	input wire logic       presetn,    // Async reset, active low
	input wire logic       wr_valid,   // Register write strobe
	input wire logic [1:0] wr_addr,    // Register select
	input wire logic [7:0] wr_data,    // Register write data
	input wire logic       wait_exec,  // Wait instruction executed
	input wire logic       int_enable, // Interrupt enable flag
	input wire logic [2:0] processor_priority_level,        // Processor priority level
	input wire logic       irq_req,    // Maskable request
	input wire logic [2:0] irq_level,  // Its priority level
	input wire logic       nmi_req,    // Non-maskable request
	input wire logic       dummy_int,  // Dummy interrupt
	input wire logic       dev_rst_n,  // Device reset, active low
	input wire logic       clk_run,    // Clocks running
	input wire logic       in_stop,    // Stop mode
	input wire logic       in_wait,    // Wait mode
	input wire logic       queue_exec, // Queued instruction ran
	input wire logic       irq_taken,  // Service started
	input wire logic [2:0] thr_rd,     // Threshold readback
	input wire logic       cpu_run,    // CPU clock enable
	input wire logic       stop_bit    // All-clock-stop bit
);
	// ****************************************
	// Helper state
	// ****************************************
	logic       unl;    // Clock write-unlock state
	logic [9:0] lo_cnt; // Device reset low cycles
	logic [2:0] lvl_wr; // Level field of a write
	logic       asleep; // Stop or wait
	logic       wake;   // Maskable wake condition
	assign lvl_wr = wr_data[2:0];
	assign asleep = in_stop || in_wait;
	assign wake   = irq_req && int_enable && (irq_level > thr_rd);
	// Unlock follows protect writes; the count runs while reset is low and clears once it rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unl    <= 1'b0;
			lo_cnt <= 10'h000;
		end else begin
			if (wr_valid && wr_addr == LPM_SEL_PROTECT)
				unl <= wr_data[LPM_UNLOCK_POS];
			lo_cnt <= dev_rst_n ? 10'h000 : lo_cnt + 10'h001;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Assertions
	// ****************************************
	AST_RST_HOLD: assert property ($rose(dev_rst_n) |-> lo_cnt >= OSC_CYC)
		else $error("device reset released too early");
	AST_WAKE_ORDER: assert property (queue_exec |-> ##2 irq_taken)
		else $error("service not two cycles after queued instruction");
	AST_STOP_UNLOCK: assert property (wr_valid && wr_addr == LPM_SEL_CM1 &&
		wr_data[LPM_STOP_POS] |-> unl && int_enable && processor_priority_level == thr_rd)
		else $error("stop written while locked or unprepared");
	AST_STOP_HALT: assert property (in_stop && stop_bit |-> !clk_run && !cpu_run)
		else $error("clocks run in stop mode");
	AST_THR_WRITE: assert property (wr_valid && wr_addr == LPM_SEL_WAKE_LVL &&
		dev_rst_n |=> thr_rd == $past(lvl_wr))
		else $error("threshold did not take written value");
	AST_NO_LOW_WAKE: assert property (asleep && dev_rst_n && !nmi_req && !wake
		|=> !queue_exec)
		else $error("wake at or below threshold");
	AST_LVL_WAKE: assert property (asleep && dev_rst_n && wake |=>
		queue_exec)
		else $error("qualifying interrupt did not wake");
	AST_RESTORE: assert property (queue_exec |-> ##[1:8]
		(wr_valid && wr_addr == LPM_SEL_WAKE_LVL && lvl_wr == LPM_THR_MAX))
		else $error("threshold not restored after exit");
	AST_DUMMY_FIRST: assert property (dummy_int |=>
		wr_valid && wr_addr == LPM_SEL_WAKE_LVL)
		else $error("dummy interrupt not followed by threshold write");
	AST_WAIT_ENTRY: assert property (wait_exec |-> int_enable && processor_priority_level == thr_rd
		##1 in_wait && clk_run && !cpu_run)
		else $error("wait entry wrong");
	AST_RESTART: assert property (queue_exec |-> clk_run && cpu_run)
		else $error("clocks not restarted on wake");
	C_WAKE: cover property (queue_exec);
	C_WAIT: cover property (wait_exec);
	C_DUMMY: cover property (dummy_int);
	C_RESET: cover property ($rose(dev_rst_n));
endmodule : lpm_properties

// ---- verif/low_power_mode_entry_exit_tb.sv ----
// Self-checking bench for the low-power controller and device pair
`timescale 1ns/1ps
module low_power_mode_entry_exit_tb;
	import lpm_pkg::*;
	localparam int OSC = 8; // Short reset hold
	logic        pclk    = 1'b0;  // System clock
	logic        presetn = 1'b0;  // Reset, active low
	logic        psel    = 1'b0;  // APB select
	logic        penable = 1'b0;  // APB enable
	logic        pwrite  = 1'b0;  // APB direction
	logic [11:0] paddr   = 12'h0; // APB address
	logic [31:0] pwdata  = 32'h0; // APB write data
	logic        irq_in  = 1'b0;  // Wake source
	logic [31:0] prdata;          // APB read data
	logic        pready;          // APB ready
	logic        cpu_run;         // CPU clock enable
	logic        stop_bit;        // Stop bit
	int          fails, n_checks, nq, nd, cyc, rl, lo_max;
	lpm_if lnk();
	lpm_cpu #(.OSC_CYC(OSC)) i_lpm_cpu (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(), .irq_in(irq_in), .lnk(lnk));
	lpm_dev i_lpm_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk), .cpu_run(cpu_run),
		.stop_bit(stop_bit));
	lpm_properties #(.OSC_CYC(OSC)) i_lpm_properties (.pclk(pclk), .presetn(presetn),
		.wr_valid(lnk.wr_valid), .wr_addr(lnk.wr_addr), .wr_data(lnk.wr_data),
		.wait_exec(lnk.wait_exec), .int_enable(lnk.int_enable), .processor_priority_level(lnk.processor_priority_level),
		.irq_req(lnk.irq_req), .irq_level(lnk.irq_level), .nmi_req(lnk.nmi_req),
		.dummy_int(lnk.dummy_int), .dev_rst_n(lnk.dev_rst_n), .clk_run(lnk.clk_run),
		.in_stop(lnk.in_stop), .in_wait(lnk.in_wait), .queue_exec(lnk.queue_exec),
		.irq_taken(lnk.irq_taken), .thr_rd(lnk.thr_rd), .cpu_run(cpu_run),
		.stop_bit(stop_bit));
	// Clock, 20 ns period
	always #10 pclk = ~pclk;
	// Count link pulses and reset length; the cycle ceiling cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (lnk.queue_exec === 1'b1) nq <= nq + 1;
		if (lnk.dummy_int === 1'b1) nd <= nd + 1;
		rl <= (lnk.dev_rst_n === 1'b0) ? rl + 1 : 0;
		if (rl > lo_max) lo_max <= rl;
		if (cyc == 20000) begin
			fails = fails + 1;
			results();
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Request held until pready is sampled high; read data taken at that same edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_st(input int pos, input logic val);
		logic [31:0] r;
		int          k;
		k = 0;
		do begin
			apb(1'b0, LPM_OFF_STATUS, 32'h0, r);
			k++;
		end while (r[pos] !== val && k < 300);
		chk("status bit", {31'h0, r[pos]}, {31'h0, val});
	endtask : wait_st
	// Model: a maskable source wakes only strictly above the threshold
	function automatic int model_wake(input int lvl, input int thr);
		return (lvl > thr) ? 1 : 0;
	endfunction : model_wake
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		int          processor_priority_level, lo, hi, q0, d0, m;
		void'($urandom(36));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, LPM_OFF_CFG, 32'h0, r);
		chk("cfg reset", r, {24'h0, LPM_CFG_RST});
		apb(1'b0, LPM_OFF_STATUS, 32'h0, r);
		chk("threshold", r[ST_THR_POS+:3], LPM_THR_MAX);
		apb(1'b1, 12'h00C, 32'hFFFFFFFF, r);
		apb(1'b0, 12'h00C, 32'h0, r);
		chk("unmapped", r, 32'h0);
		$display("test reset done");
		// Stop and wait alternately, refused then qualifying level
		for (int i = 0; i < 4; i++) begin
			m   = i % 2;
			processor_priority_level = $urandom_range(5, 0);
			lo  = $urandom_range(processor_priority_level, 0);
			hi  = $urandom_range(7, processor_priority_level + 1);
			q0  = nq;
			apb(1'b1, LPM_OFF_CFG, 32'((processor_priority_level << CFG_IPL_POS) | lo), r);
			apb(1'b1, LPM_OFF_CTRL, 32'(1 << m), r);
			wait_st(ST_STOP_POS + m, 1'b1);
			irq_in <= 1'b1;
			repeat (20) @(posedge pclk);
			@(negedge pclk);
			chk("clk_run", lnk.clk_run, 32'(m));
			chk("cpu_run", cpu_run, 32'h0);
			chk("stop_bit", stop_bit, 32'(1 - m));
			chk("low level", 32'(nq - q0), 32'(model_wake(lo, processor_priority_level)));
			apb(1'b1, LPM_OFF_CFG, 32'((processor_priority_level << CFG_IPL_POS) | hi), r);
			wait_st(ST_STOP_POS + m, 1'b0);
			wait_st(ST_BUSY_POS, 1'b0);
			irq_in <= 1'b0;
			chk("wake", 32'(nq - q0), 32'(model_wake(hi, processor_priority_level)));
			apb(1'b0, LPM_OFF_STATUS, 32'h0, r);
			chk("woke", r[ST_WOKE_POS], 32'h1);
			chk("thr back", r[ST_THR_POS+:3], LPM_THR_MAX);
			apb(1'b1, LPM_OFF_STATUS, 32'h10, r);
		end
		$display("test stop and wait done");
		// NMI exit, then the next stop owes a dummy interrupt
		apb(1'b1, LPM_OFF_CFG, 32'h32, r);
		apb(1'b1, LPM_OFF_CTRL, 32'h1, r);
		wait_st(ST_STOP_POS, 1'b1);
		apb(1'b1, LPM_OFF_CTRL, 32'h8, r);
		wait_st(ST_BUSY_POS, 1'b0);
		apb(1'b0, LPM_OFF_STATUS, 32'h0, r);
		chk("dummy owed", r[ST_DUMMY_POS], 32'h1);
		d0 = nd;
		apb(1'b1, LPM_OFF_CTRL, 32'h1, r);
		wait_st(ST_STOP_POS, 1'b1);
		chk("dummy", 32'(nd - d0), 32'h1);
		irq_in <= 1'b1;
		apb(1'b1, LPM_OFF_CFG, 32'h35, r);
		wait_st(ST_STOP_POS, 1'b0);
		wait_st(ST_BUSY_POS, 1'b0);
		irq_in <= 1'b0;
		$display("test nmi done");
		// Hardware reset command holds the device reset long enough
		apb(1'b1, LPM_OFF_CTRL, 32'h4, r);
		wait_st(ST_BUSY_POS, 1'b0);
		chk("reset hold", 32'(lo_max >= OSC), 32'h1);
		apb(1'b0, LPM_OFF_STATUS, 32'h0, r);
		chk("thr after reset", r[ST_THR_POS+:3], LPM_THR_MAX);
		$display("test reset command done");
		results();
	end
endmodule : low_power_mode_entry_exit_tb
